// ==== rtl/vfd_blink_gen.sv ====
// Blink phase generator clocked by multiplex oscillator enables
`timescale 1ns/1ps
module vfd_blink_gen
  import vfd_pkg::*;
#(
  parameter int SLOW_TICKS = BLINK_SLOW_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic tick_en,
  input wire logic fast,
  input wire logic clear,
  // Status
  output logic phase
);
  localparam logic [BLINK_CW-1:0] SLOW_LAST = BLINK_CW'(SLOW_TICKS - 1);
  localparam logic [BLINK_CW-1:0] FAST_LAST = BLINK_CW'(SLOW_TICKS / 2 - 1);

  logic [BLINK_CW-1:0] cnt_r;
  logic [BLINK_CW-1:0] last;

  assign last = fast ? FAST_LAST : SLOW_LAST;

  // Half period counts oscillator ticks, so it scales with the oscillator
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      cnt_r <= '0;
      phase <= 1'b0;
    end else if (tick_en) begin
      if (cnt_r >= last) begin
        cnt_r <= '0;
        phase <= ~phase;
      end else begin
        cnt_r <= cnt_r + BLINK_ONE;
      end
    end
  end

  AST_BLINK_CLEAR: assert property (@(posedge clk) disable iff (srst)
    clear |=> (cnt_r == '0) && !phase)
    else $error("blink counters not cleared");
  AST_BLINK_TOGGLE: assert property (@(posedge clk) disable iff (srst)
    (tick_en && !clear && cnt_r >= last) |=> phase != $past(phase))
    else $error("blink phase did not toggle at end of half period");
endmodule

// ==== rtl/vfd_ctrl_i2c_config.sv ====
// Two-wire slave with configuration, lock-protected registers and blink control
`timescale 1ns/1ps
module vfd_ctrl_i2c_config
  import vfd_pkg::*;
#(
  parameter int BLINK_TICKS = BLINK_SLOW_TICKS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Serial bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // Address strap pin
  input wire logic ADDR_STRAP_PIN_IN,
  // Multiplex engine handshake
  input wire logic MULTIPLEX_CLOCK_EN,
  input wire logic MUX_CYCLE_END,
  output logic MUX_RESTART,
  output logic CLEAR_DIGITS,
  // Configuration outputs
  output logic SHUTDOWN,
  output logic CFG_LOCKED,
  output logic FAST_BLINK,
  output logic FONT16_SEL,
  output logic MODE_96_2,
  output logic BLINK_PHASE,
  output logic [7:0] SCAN_LENGTH,
  output logic [7:0] GRID_COUNT
);
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic strap_s1, strap_s2;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic strap_at_start_r, strap_at_low_r, strap_wait_r;
  logic [1:0] slave_addr_low_bits;
  vfd_state_type state_r;
  logic [3:0] bitcnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic cmd_phase_r;
  logic [6:0] ptr_r;
  logic wr_stb_r;
  logic [6:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic rd_stb_r;
  logic [6:0] rd_addr_r;
  logic [7:0] cfg_r;
  logic resync_pend_r;
  logic [OMAP_AW-1:0] omap_ptr_r;
  logic [7:0] omap_mem_r [OMAP_DEPTH];
  logic blink_phase;
  logic blink_clear;

  // Pointer advance: font and map data ports and the last address hold
  function automatic logic [6:0] next_ptr(input logic [6:0] p);
    if (p == FONT_ADDR || p == OMAP_DATA_ADDR || p == LAST_ADDR) begin
      next_ptr = p;
    end else begin
      next_ptr = p + PTR_STEP;
    end
  endfunction

  function automatic logic [7:0] read_reg(input logic [6:0] p);
    unique case (p)
      CFG_ADDR: read_reg = {blink_phase, cfg_r[CFG_M:CFG_S]};
      SCAN_ADDR: read_reg = SCAN_LENGTH;
      GRID_ADDR: read_reg = GRID_COUNT;
      OMAP_DATA_ADDR: read_reg = omap_mem_r[omap_ptr_r];
      OMAP_PTR_ADDR: read_reg = {{(8 - OMAP_AW){1'b0}}, omap_ptr_r};
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Pin synchronisers; SCL is only ever sampled
  always_ff @(posedge CLK) begin
    if (SRST) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      scl_s1 <= SCL_IN;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= SDA_IN;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      strap_s1 <= ADDR_STRAP_PIN_IN;
      strap_s2 <= strap_s1;
    end
  end

  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;

  // Strap is sampled with SCL high/SDA low at start, then at first SCL low,
  // when SDA carries the leading one of the address
  always_ff @(posedge CLK) begin
    if (SRST) begin
      strap_at_start_r <= 1'b0;
      strap_at_low_r <= 1'b0;
      strap_wait_r <= 1'b0;
    end else if (start_det) begin
      strap_at_start_r <= strap_s2;
      strap_wait_r <= 1'b1;
    end else if (strap_wait_r && !scl_s2 && !scl_d) begin
      strap_at_low_r <= strap_s2;
      strap_wait_r <= 1'b0;
    end
  end

  // GND 00, supply 01, SDA 10, SCL 11
  assign slave_addr_low_bits = {strap_at_start_r ^ strap_at_low_r, strap_at_start_r};

  // Serial protocol engine; bits sampled on SCL rise, driven after SCL fall
  always_ff @(posedge CLK) begin
    wr_stb_r <= 1'b0;
    rd_stb_r <= 1'b0;
    CLEAR_DIGITS <= 1'b0;
    if (SRST) begin
      state_r <= ST_IDLE;
      bitcnt_r <= '0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      cmd_phase_r <= 1'b1;
      ptr_r <= '0;
      wr_addr_r <= '0;
      wr_data_r <= 8'h00;
      rd_addr_r <= '0;
      SDA_OUT <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      SDA_OE_N <= 1'b1;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      bitcnt_r <= '0;
      cmd_phase_r <= 1'b1;
      SDA_OE_N <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          SDA_OE_N <= 1'b1;
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise && bitcnt_r < BITS_PER_BYTE) begin
            rx_r <= {rx_r[6:0], sda_s2};
            bitcnt_r <= bitcnt_r + BIT_STEP;
          end else if (scl_fall && bitcnt_r == BITS_PER_BYTE) begin
            if (state_r == ST_ADDR) begin
              if (rx_r[7:1] == {ADDR_HI, slave_addr_low_bits}) begin
                SDA_OE_N <= 1'b0;
                rw_r <= rx_r[0];
                state_r <= ST_ADDR_ACK;
              end else begin
                state_r <= ST_IDLE;
              end
            end else begin
              SDA_OE_N <= 1'b0;
              state_r <= ST_WR_ACK;
              if (cmd_phase_r) begin
                ptr_r <= rx_r[6:0];
                cmd_phase_r <= 1'b0;
              end else begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= rx_r;
                ptr_r <= next_ptr(ptr_r);
                CLEAR_DIGITS <= (ptr_r == CFG_ADDR) && rx_r[CFG_R];
              end
            end
          end
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          if (state_r == ST_RD_ACK && scl_rise && sda_s2) begin
            state_r <= ST_IDLE;
          end else if (scl_fall) begin
            bitcnt_r <= '0;
            if (rw_r) begin
              tx_r <= read_reg(ptr_r);
              SDA_OE_N <= read_reg(ptr_r)[7];
              rd_stb_r <= 1'b1;
              rd_addr_r <= ptr_r;
              ptr_r <= next_ptr(ptr_r);
              state_r <= ST_READ;
            end else begin
              SDA_OE_N <= 1'b1;
              state_r <= ST_WRITE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            SDA_OE_N <= 1'b1;
            bitcnt_r <= '0;
            state_r <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (bitcnt_r == LAST_TX_SHIFT) begin
              SDA_OE_N <= 1'b1;
              state_r <= ST_RD_ACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              SDA_OE_N <= tx_r[6];
              bitcnt_r <= bitcnt_r + BIT_STEP;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Configuration register; the phase bit is never stored
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cfg_r <= CFG_RESET;
    end else if (wr_stb_r && wr_addr_r == CFG_ADDR) begin
      cfg_r <= {1'b0, wr_data_r[CFG_M:CFG_S]};
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SHUTDOWN <= 1'b1;
      CFG_LOCKED <= 1'b0;
      FAST_BLINK <= 1'b0;
      FONT16_SEL <= 1'b0;
      MODE_96_2 <= 1'b0;
      BLINK_PHASE <= 1'b0;
    end else begin
      SHUTDOWN <= !cfg_r[CFG_S];
      CFG_LOCKED <= cfg_r[CFG_L];
      FAST_BLINK <= cfg_r[CFG_B];
      FONT16_SEL <= cfg_r[CFG_F];
      MODE_96_2 <= cfg_r[CFG_M];
      BLINK_PHASE <= blink_phase;
    end
  end

  // Lock-protected registers: bus still acknowledges, data is dropped
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SCAN_LENGTH <= SCAN_RESET;
      GRID_COUNT <= GRID_RESET;
    end else if (wr_stb_r && !cfg_r[CFG_L]) begin
      if (wr_addr_r == SCAN_ADDR) begin
        SCAN_LENGTH <= wr_data_r;
      end
      if (wr_addr_r == GRID_ADDR) begin
        GRID_COUNT <= wr_data_r;
      end
    end
  end

  // Output map storage; the pointer stays writable under lock
  always_ff @(posedge CLK) begin
    if (SRST) begin
      omap_ptr_r <= '0;
      for (int i = 0; i < OMAP_DEPTH; i++) begin
        omap_mem_r[i] <= OMAP_RESET;
      end
    end else if (wr_stb_r && wr_addr_r == OMAP_PTR_ADDR) begin
      omap_ptr_r <= wr_data_r[OMAP_AW-1:0];
    end else if (wr_stb_r && wr_addr_r == OMAP_DATA_ADDR) begin
      if (!cfg_r[CFG_L]) begin
        omap_mem_r[omap_ptr_r] <= wr_data_r;
      end
      omap_ptr_r <= omap_ptr_r + OMAP_STEP;
    end else if (rd_stb_r && rd_addr_r == OMAP_DATA_ADDR) begin
      omap_ptr_r <= omap_ptr_r + OMAP_STEP;
    end
  end

  // Resync request waits for the end of the running multiplex cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      resync_pend_r <= 1'b0;
      MUX_RESTART <= 1'b0;
    end else begin
      MUX_RESTART <= resync_pend_r && MUX_CYCLE_END;
      if (wr_stb_r && wr_addr_r == CFG_ADDR && wr_data_r[CFG_T]) begin
        resync_pend_r <= 1'b1;
      end else if (MUX_CYCLE_END) begin
        resync_pend_r <= 1'b0;
      end
    end
  end

  assign blink_clear = resync_pend_r && MUX_CYCLE_END;

  vfd_blink_gen #(
    .SLOW_TICKS(BLINK_TICKS)
  ) u_blink (
    .clk(CLK),
    .srst(SRST),
    .tick_en(MULTIPLEX_CLOCK_EN),
    .fast(cfg_r[CFG_B]),
    .clear(blink_clear),
    .phase(blink_phase)
  );

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  AST_SHUTDOWN_BIT: assert property (
    (wr_stb_r && wr_addr_r == CFG_ADDR) |=> ##1 SHUTDOWN == !$past(wr_data_r[CFG_S], 2))
    else $error("shutdown output does not follow written bit");
  AST_LOCK_HOLDS: assert property (
    (wr_stb_r && cfg_r[CFG_L] && (wr_addr_r == SCAN_ADDR || wr_addr_r == GRID_ADDR))
    |=> $stable(SCAN_LENGTH) && $stable(GRID_COUNT))
    else $error("locked register changed");
  AST_MAP_PTR_WRITABLE: assert property (
    (wr_stb_r && wr_addr_r == OMAP_PTR_ADDR) |=> omap_ptr_r == $past(wr_data_r[OMAP_AW-1:0]))
    else $error("map pointer write lost");
  AST_RESYNC_END: assert property (
    (resync_pend_r && MUX_CYCLE_END) |=> MUX_RESTART && !resync_pend_r)
    else $error("restart not issued at cycle end");
  AST_CLEAR_IN_ACK: assert property (
    CLEAR_DIGITS |-> !SDA_OE_N && state_r == ST_WR_ACK)
    else $error("digit clear outside acknowledge");
  AST_PHASE_READ: assert property (
    (rd_stb_r && rd_addr_r == CFG_ADDR) |-> tx_r[CFG_P] == $past(blink_phase))
    else $error("read phase bit wrong");
  AST_ACK_HELD: assert property (
    (state_r == ST_WR_ACK && !stop_det && !start_det && !scl_fall) |-> !SDA_OE_N)
    else $error("acknowledge released early");
  AST_START_ADDR: assert property (
    (start_det && !stop_det) |=> state_r == ST_ADDR && bitcnt_r == '0 && SDA_OE_N)
    else $error("start not recognised");
  AST_AUTOINC: assert property (
    (state_r == ST_WRITE && scl_fall && bitcnt_r == BITS_PER_BYTE && !cmd_phase_r
     && !start_det && !stop_det && ptr_r == SCAN_ADDR) |=> ptr_r == $past(ptr_r) + PTR_STEP)
    else $error("pointer did not advance");
  AST_PHASE_RO: assert property (
    (wr_stb_r && wr_addr_r == CFG_ADDR) |=> !cfg_r[CFG_P])
    else $error("phase bit stored");

  COV_CFG_WRITE: cover property (wr_stb_r && wr_addr_r == CFG_ADDR);
  COV_CFG_READ: cover property (rd_stb_r && rd_addr_r == CFG_ADDR);
  COV_RESTART: cover property (MUX_RESTART);
  COV_CLEAR: cover property (CLEAR_DIGITS);
endmodule

// ==== rtl/vfd_pkg.sv ====
// Shared constants and types for the display configuration slave
package vfd_pkg;
  // Slave address: fixed upper bits, low two bits come from the strap pin
  localparam logic [4:0] ADDR_HI = 5'h1D;
  // Register pointer values
  localparam logic [6:0] GRID_ADDR = 7'h03;
  localparam logic [6:0] CFG_ADDR = 7'h04;
  localparam logic [6:0] FONT_ADDR = 7'h05;
  localparam logic [6:0] OMAP_DATA_ADDR = 7'h06;
  localparam logic [6:0] OMAP_PTR_ADDR = 7'h0D;
  localparam logic [6:0] SCAN_ADDR = 7'h0E;
  localparam logic [6:0] LAST_ADDR = 7'h7F;
  localparam logic [6:0] PTR_STEP = 7'h01;
  // Configuration bit positions
  localparam int CFG_S = 0;
  localparam int CFG_L = 1;
  localparam int CFG_B = 2;
  localparam int CFG_F = 3;
  localparam int CFG_T = 4;
  localparam int CFG_R = 5;
  localparam int CFG_M = 6;
  localparam int CFG_P = 7;
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] SCAN_RESET = 8'h00;
  localparam logic [7:0] GRID_RESET = 8'h00;
  localparam logic [7:0] OMAP_RESET = 8'h00;
  // Output map storage
  localparam int OMAP_DEPTH = 8;
  localparam int OMAP_AW = 3;
  localparam logic [OMAP_AW-1:0] OMAP_STEP = 3'h1;
  // Bit counting on the serial link
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_SHIFT = 4'h7;
  localparam logic [3:0] BIT_STEP = 4'h1;
  // Blink half periods, in ms, at the nominal oscillator rate in kHz
  localparam int BLINK_SLOW_MS = 1000;
  localparam int BLINK_FAST_MS = 500;
  localparam int OSC_KHZ = 4000;
  localparam int BLINK_SLOW_TICKS = BLINK_SLOW_MS * OSC_KHZ;
  localparam int BLINK_FAST_TICKS = BLINK_FAST_MS * OSC_KHZ;
  localparam int BLINK_CW = 23;
  localparam logic [BLINK_CW-1:0] BLINK_ONE = 23'h000001;
  // Serial protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h2,
    ST_WRITE = 3'h3,
    ST_WR_ACK = 3'h4,
    ST_READ = 3'h5,
    ST_RD_ACK = 3'h6
  } vfd_state_type;
endpackage

// ==== verification/testbench.sv ====
// Self-checking bench for the display configuration slave
`timescale 1ns/1ps
module testbench
  import vfd_pkg::*;
;
  localparam int TICKS = 8;
  logic clk, srst, scl, sda, sda_out, sda_oe_n, strap, mce, mend, restart, clr;
  logic shutdown, locked, fast, font16, mode, phase, res_valid;
  logic [7:0] scan, grid, res_data, g, sc;
  logic [1:0] strap_sel = 2'h0;
  logic [7:0] exp_q[$];
  logic [7:0] cv[3] = '{8'h45, 8'h8B, 8'h00};
  logic [1:0] sels[3] = '{2'h0, 2'h1, 2'h3};
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_clr = 0;
  int n_rst = 0;
  int seed = 32'h40DC8030;
  // Strap tied low, high, or to the clock line
  assign strap = (strap_sel == 2'h3) ? scl : strap_sel[0];
  vfd_ctrl_i2c_config #(.BLINK_TICKS(TICKS)) i_dut (
    .CLK(clk), .SRST(srst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .ADDR_STRAP_PIN_IN(strap), .MULTIPLEX_CLOCK_EN(mce),
    .MUX_CYCLE_END(mend), .MUX_RESTART(restart), .CLEAR_DIGITS(clr),
    .SHUTDOWN(shutdown), .CFG_LOCKED(locked), .FAST_BLINK(fast), .FONT16_SEL(font16),
    .MODE_96_2(mode), .BLINK_PHASE(phase), .SCAN_LENGTH(scan), .GRID_COUNT(grid)
  );
  vfd_i2c_master i_mst (
    .clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda),
    .res_valid(res_valid), .res_data(res_data)
  );
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] p, input logic [7:0] d, input bit with_d);
    i_mst.start();
    exp_q.push_back(8'h01);
    i_mst.wr_byte({ADDR_HI, strap_sel, 1'b0});
    exp_q.push_back(8'h01);
    i_mst.wr_byte({1'b0, p});
    if (with_d) begin
      exp_q.push_back(8'h01);
      i_mst.wr_byte(d);
    end
  endtask
  task automatic rd_open();
    i_mst.start();
    exp_q.push_back(8'h01);
    i_mst.wr_byte({ADDR_HI, strap_sel, 1'b1});
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    i_mst.rd_byte(last);
  endtask
  task automatic fin();
    i_mst.stop();
    repeat (6) @(negedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk) mce = 1'b1;
      @(negedge clk) mce = 1'b0;
    end
    repeat (3) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Result watcher and run limit
  always @(posedge clk) begin
    cycles++;
    n_clr += int'(clr);
    n_rst += int'(restart);
    if (res_valid) check(res_data, exp_q.pop_front());
    if (cycles == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    srst = 1'b1;
    mce = 1'b0;
    mend = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    repeat (4) @(negedge clk);
    check({sda_out, shutdown, locked, fast, font16, mode, phase, sda_oe_n}, 8'h41);
    check(scan | grid, 8'h00);
    for (int i = 0; i < 3; i++) begin
      strap_sel = sels[i];
      wr(CFG_ADDR, cv[i], 1'b1);
      fin();
      check({3'h0, mode, font16, fast, locked, shutdown},
            {3'h0, cv[i][6], cv[i][3:1], ~cv[i][0]});
      wr(CFG_ADDR, 8'h00, 1'b0);
      rd_open();
      rd({1'b0, cv[i][6:0]}, 1'b1);
      fin();
    end
    strap_sel = 2'h0;
    i_mst.start();
    exp_q.push_back(8'h00);
    i_mst.wr_byte({ADDR_HI, 2'h1, 1'b0});
    fin();
    g = 8'($random(seed));
    sc = 8'($random(seed));
    wr(GRID_ADDR, g, 1'b1);
    exp_q.push_back(8'h01);
    i_mst.wr_byte(8'h01);
    fin();
    check(grid, g);
    check({7'h0, shutdown}, 8'h00);
    wr(GRID_ADDR, 8'h00, 1'b0);
    rd_open();
    rd(g, 1'b0);
    rd(8'h01, 1'b1);
    fin();
    wr(SCAN_ADDR, sc, 1'b1);
    fin();
    check(scan, sc);
    wr(CFG_ADDR, 8'h03, 1'b1);
    fin();
    wr(SCAN_ADDR, ~sc, 1'b1);
    fin();
    wr(GRID_ADDR, ~g, 1'b1);
    fin();
    check(scan, sc);
    check(grid, g);
    wr(OMAP_PTR_ADDR, 8'h05, 1'b1);
    fin();
    wr(OMAP_PTR_ADDR, 8'h00, 1'b0);
    rd_open();
    rd(8'h05, 1'b1);
    fin();
    wr(SCAN_ADDR, 8'h00, 1'b0);
    rd_open();
    rd(sc, 1'b1);
    fin();
    check(n_clr[7:0], 8'h00);
    wr(CFG_ADDR, 8'h21, 1'b1);
    fin();
    check(n_clr[7:0], 8'h01);
    tick(TICKS - 1);
    check({7'h0, phase}, 8'h00);
    tick(1);
    check({7'h0, phase}, 8'h01);
    wr(CFG_ADDR, 8'h15, 1'b1);
    fin();
    check({7'h0, phase}, 8'h01);
    @(negedge clk) mend = 1'b1;
    @(negedge clk) mend = 1'b0;
    repeat (3) @(negedge clk);
    check({7'h0, phase}, 8'h00);
    check(n_rst[7:0], 8'h01);
    tick(TICKS / 2 - 1);
    check({7'h0, phase}, 8'h00);
    tick(1);
    check({7'h0, phase}, 8'h01);
    wr(CFG_ADDR, 8'h00, 1'b0);
    rd_open();
    rd(8'h95, 1'b1);
    fin();
    give_verdict();
  end
endmodule

// ==== verification/vfd_i2c_master.sv ====
// Behavioural two-wire bus master that frames and clocks every transfer
`timescale 1ns/1ps
module vfd_i2c_master (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda,
  // Observed results: ack flag for writes, data for reads
  output logic res_valid,
  output logic [7:0] res_data
);
  logic sda_drv_r = 1'b1;
  // Pulled-up line is low whenever either party pulls it
  assign sda = sda_drv_r & sda_oe_n;
  initial begin
    scl = 1'b1;
    res_valid = 1'b0;
    res_data = 8'h00;
  end
  task automatic hp();
    repeat (5) @(negedge clk);
  endtask
  task automatic post(input logic [7:0] v);
    res_data = v;
    res_valid = 1'b1;
    @(negedge clk);
    res_valid = 1'b0;
  endtask
  // Also serves as repeated start, entered with the clock low
  task automatic start();
    sda_drv_r = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_drv_r = 1'b0;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_drv_r = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drv_r = 1'b1;
    hp();
  endtask
  // Data changes only well after the clock fall, so no false start or stop
  task automatic bit_x(input logic b, output logic s);
    sda_drv_r = b;
    hp();
    scl = 1'b1;
    hp();
    s = sda;
    scl = 1'b0;
    hp();
  endtask
  task automatic wr_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    post({7'h00, ~s});
  endtask
  task automatic rd_byte(input logic last);
    logic s;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(last, s);
    post(d);
  endtask
endmodule
